//--- rtl/ebtc_timer.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
module ebtc_timer
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// power-on indication, high on the first reset only
	input wire logic power_on,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// external timer clock pin
	input wire logic external_timer_clock_pin_in,
	output logic external_timer_clock_pin_oe,
	// option bits without counter effect
	output logic wake_on_change_disable,
	output logic weak_pullup_disable
);
	// bus address phase capture
	logic wr_pend, next_wr_pend;
	logic [7:0] addr_q, next_addr_q;
	logic [31:0] next_hrdata;
	// registers
	logic [7:0] timer_count, next_timer_count;
	logic [7:0] timer_pin_config, next_timer_pin_config;
	logic [5:0] pin_direction_control, next_pin_direction_control;
	logic next_pin_oe;
	// counting machinery
	logic [1:0] instr_div, next_instr_div;
	logic [1:0] hold, next_hold;
	logic [7:0] prescale, next_prescale;
	logic pin_q, next_pin_q;
	logic cnt_valid, next_cnt_valid;
	logic addr_ok, rd_ok;
	logic tick, ext_edge, src_tick, inc;
	logic [8:0] rate_mask;

	// prescaler tap for a given rate, divide is 2^(rate+1)
	function automatic logic [8:0] ebtc_tap(input logic [2:0] rate);
		// widened so that rate seven does not wrap to a shift of zero
		ebtc_tap = 9'h001 << ({1'b0, rate} + 4'h1);
	endfunction

	// address phase decode
	always_comb
	begin
		addr_ok = hsel && hready && htrans[1];
		rd_ok = addr_ok && !hwrite;
	end

	// tick and edge generation
	always_comb
	begin
		tick = (instr_div == ebtc_pkg::ebtc_instr_div_last);
		ext_edge = timer_pin_config[ebtc_pkg::ebtc_bit_edge]
			? (pin_q && !external_timer_clock_pin_in)
			: (!pin_q && external_timer_clock_pin_in);
		src_tick = timer_pin_config[ebtc_pkg::ebtc_bit_source]
			? ext_edge : tick;
		rate_mask = ebtc_tap(timer_pin_config[ebtc_pkg::ebtc_rate_msb:
			ebtc_pkg::ebtc_rate_lsb]);
		// prescale bit toggling from one to zero marks a divided tick
		if (timer_pin_config[ebtc_pkg::ebtc_bit_assign])
			inc = src_tick; // prescaler given away: direct count
		else
			// low rate+1 prescale bits all ones: wraps on this tick
			inc = src_tick && (({1'b0, prescale} & (rate_mask - 9'h001))
				== (rate_mask - 9'h001));
	end

	// next-state for bus, registers and counter
	always_comb
	begin
		next_wr_pend = addr_ok && hwrite;
		next_addr_q = addr_ok ? haddr : addr_q;
		next_timer_count = timer_count;
		next_timer_pin_config = timer_pin_config;
		next_pin_direction_control = pin_direction_control;
		next_hold = hold;
		next_cnt_valid = cnt_valid;
		next_instr_div = instr_div + 2'h1;
		next_pin_q = external_timer_clock_pin_in;
		next_prescale = prescale;
		if (src_tick && !timer_pin_config[ebtc_pkg::ebtc_bit_assign])
			next_prescale = prescale + 8'h01;
		// counter advance unless held after a write
		if (tick && hold != 2'h0)
			next_hold = hold - 2'h1;
		else if (hold == 2'h0 && inc)
			next_timer_count = timer_count + 8'h01;
		if (wr_pend)
		begin
			case (addr_q)
				ebtc_pkg::ebtc_addr_count:
				begin
					next_timer_count = hwdata[7:0];
					next_hold = ebtc_pkg::ebtc_write_hold;
					next_prescale = 8'h00;
					next_cnt_valid = 1'b1;
				end
				ebtc_pkg::ebtc_addr_option:
					next_timer_pin_config = hwdata[7:0];
				ebtc_pkg::ebtc_addr_direction:
					next_pin_direction_control = hwdata[5:0];
				default:
					next_timer_count = next_timer_count;
			endcase
		end
		// pin drives only when not an input and not taken by the timer
		next_pin_oe = !next_pin_direction_control[ebtc_pkg::ebtc_pin_index]
			&& !next_timer_pin_config[ebtc_pkg::ebtc_bit_source];
		next_hrdata = hrdata;
		if (rd_ok)
		begin
			case (haddr)
				ebtc_pkg::ebtc_addr_count:
					next_hrdata = {24'h000000, timer_count};
				ebtc_pkg::ebtc_addr_option:
					next_hrdata = {24'h000000, timer_pin_config};
				ebtc_pkg::ebtc_addr_direction:
					next_hrdata = {26'h0000000, pin_direction_control};
				ebtc_pkg::ebtc_addr_status:
					next_hrdata = {30'h00000000, hold != 2'h0, cnt_valid};
				default:
					next_hrdata = 32'h00000000;
			endcase
		end
	end

	// bus capture and read data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h00000000;
		end
		else
		begin
			wr_pend <= next_wr_pend;
			addr_q <= next_addr_q;
			hrdata <= next_hrdata;
		end
	end

	// option and direction registers, reset on every reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			timer_pin_config <= ebtc_pkg::ebtc_option_reset;
			pin_direction_control <= ebtc_pkg::ebtc_direction_reset;
			external_timer_clock_pin_oe <= 1'b0;
		end
		else
		begin
			timer_pin_config <= next_timer_pin_config;
			pin_direction_control <= next_pin_direction_control;
			external_timer_clock_pin_oe <= next_pin_oe;
		end
	end

	// divider, write hold, prescaler and pin edge history
	// pin history resets low to match the idle pin, no false edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			instr_div <= 2'h0;
			hold <= 2'h0;
			prescale <= 8'h00;
			pin_q <= 1'b0;
		end
		else
		begin
			instr_div <= next_instr_div;
			hold <= next_hold;
			prescale <= next_prescale;
			pin_q <= next_pin_q;
		end
	end

	// power-on clears; other resets keep count and validity
	// no async branch: the count must survive a warm reset

	// count survives warm resets; power-on loads ebtc_count_power_on and marks it undefined
	always_ff @(posedge hclk)
	begin
		if (!hresetn && power_on)
		begin
			timer_count <= ebtc_pkg::ebtc_count_power_on;
			cnt_valid <= 1'b0;
		end
		else if (hresetn)
		begin
			timer_count <= next_timer_count;
			cnt_valid <= next_cnt_valid;
		end
	end

	// fixed ahb answers and inert option bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wake_on_change_disable <= 1'b1;
			weak_pullup_disable <= 1'b1;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wake_on_change_disable <= timer_pin_config[7];
			weak_pullup_disable <= timer_pin_config[6];
		end
	end
endmodule

//--- common/ebtc_pkg.sv
package ebtc_pkg;
	// byte addresses on the register bus
	localparam logic [7:0] ebtc_addr_count = 8'h04;
	localparam logic [7:0] ebtc_addr_option = 8'h08;
	localparam logic [7:0] ebtc_addr_direction = 8'h0C;
	localparam logic [7:0] ebtc_addr_status = 8'h10;
	// documented register index of the count
	localparam int ebtc_count_index = 1;
	// reset values
	localparam logic [7:0] ebtc_option_reset = 8'hFF;
	localparam logic [5:0] ebtc_direction_reset = 6'h3F;
	localparam logic [7:0] ebtc_count_power_on = 8'h00;
	// option field positions
	localparam int ebtc_bit_source = 5;
	localparam int ebtc_bit_edge = 4;
	localparam int ebtc_bit_assign = 3;
	localparam int ebtc_rate_msb = 2;
	localparam int ebtc_rate_lsb = 0;
	// timer pin position in the direction register
	localparam int ebtc_pin_index = 2;
	// cycles the count holds after a write
	localparam logic [1:0] ebtc_write_hold = 2'h2;
	// instruction cycle is four bus clocks
	localparam logic [1:0] ebtc_instr_div_last = 2'h3;
endpackage

//--- test/ebtc_checker.sv
`timescale 1ns/10ps
module ebtc_chk
(
	// bus side
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// pin and inert option bits
	input wire logic external_timer_clock_pin_oe,
	input wire logic wake_on_change_disable,
	input wire logic weak_pullup_disable
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// taken reads and option writes
	wire rd = hsel && htrans[1] && !hwrite;
	wire wo = hsel && htrans[1] && hwrite && haddr == 8'h08;
	property p_ok;
		hreadyout && !hresp;
	endproperty
	a_ok: assert property (p_ok) else $error("wait or error");
	property p_top;
		$past(rd && haddr == 8'h04) |-> hrdata[31:8] == 24'h0;
	endproperty
	a_top: assert property (p_top) else $error("count width");
	property p_hold;
		$changed(hrdata) |-> $past(rd);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst;
		$rose(hresetn) |-> hrdata == 32'h0 && !external_timer_clock_pin_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_opt;
		$rose(hresetn) |-> wake_on_change_disable && weak_pullup_disable;
	endproperty
	a_opt: assert property (p_opt) else $error("option reset");
	property p_keep;
		$changed(wake_on_change_disable) |-> $past(wo, 3);
	endproperty
	a_keep: assert property (p_keep) else $error("option moved");
	c_rd: cover property (rd && haddr == 8'h04);
	c_oe: cover property ($rose(external_timer_clock_pin_oe));
	c_wk: cover property ($fell(wake_on_change_disable));
endmodule
bind ebtc_timer ebtc_chk ebtc_chk_inst (.*);

//--- test/ebtc_pin_src.sv
`timescale 1ns/10ps
module ebtc_pin_src
(
	// request
	input wire logic hclk,
	input wire logic start,
	// pin and state
	output logic pin = 1'b0,
	output logic busy = 1'b0
);
	// five pulses, each level eight clocks, idle low
	always @(posedge hclk)
	begin
		if (start)
		begin
			busy <= 1'b1;
			repeat (5)
			begin
				repeat (8) @(posedge hclk);
				pin <= 1'b1;
				repeat (8) @(posedge hclk);
				pin <= 1'b0;
			end
			busy <= 1'b0;
		end
	end
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic hclk = 0;
	logic hresetn = 0;
	logic pwr = 1;
	logic hsel = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 0;
	logic [31:0] hwdata = 32'h0;
	logic start = 0;
	logic [31:0] q;
	logic [31:0] hrdata;
	logic rdy, hresp, pin, oe, wk, pu, busy;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	always #4 hclk = !hclk;
	// hang guard
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			stop_test();
		end
	end
	ebtc_timer ebtc_timer_inst (.hclk(hclk), .hresetn(hresetn),
		.power_on(pwr), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
		.hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
		.external_timer_clock_pin_in(pin),
		.external_timer_clock_pin_oe(oe),
		.wake_on_change_disable(wk), .weak_pullup_disable(pu));
	ebtc_pin_src ebtc_pin_src_inst (.hclk(hclk), .start(start),
		.pin(pin), .busy(busy));
	task stop_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// one single transfer
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		q = hrdata;
	endtask
	task t_reset();
		acc(0, 8'h08, 0);
		chk(q, 32'hFF);
		acc(0, 8'h20, 0);
		chk(q, 0);
		chk(32'({wk, pu, oe}), 32'h6);
		acc(0, 8'h10, 0);
		chk(q, 0);
		acc(1, 8'h0C, 0);
		repeat (2) @(posedge hclk);
		chk(32'(oe), 0);
		acc(1, 8'h08, 0);
		repeat (2) @(posedge hclk);
		chk(32'(oe), 1);
	endtask
	// every rate, about eight counts over the wait
	task t_rate();
		for (int r = 0; r < 8; r++)
		begin
			acc(1, 8'h08, r);
			acc(1, 8'h04, 32'h10);
			acc(0, 8'h04, 0);
			chk(q, 32'h10);
			repeat (64 << r) @(posedge hclk);
			acc(0, 8'h04, 0);
			chk(32'(q >= 32'h16 && q <= 32'h18), 1);
		end
	endtask
	// rising then falling pin edges, one count each
	task t_ext();
		acc(1, 8'h04, 0);
		for (int e = 0; e < 2; e++)
		begin
			acc(1, 8'h08, 32'h28 | (e << 4));
			repeat (16) @(posedge hclk);
			start <= 1'b1;
			@(posedge hclk);
			start <= 1'b0;
			do @(posedge hclk); while (busy);
			acc(0, 8'h04, 0);
			chk(q, 5 + 5 * e);
		end
	endtask
	task t_warm();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		acc(0, 8'h04, 0);
		chk(q, 32'hA);
		acc(0, 8'h10, 0);
		chk(q, 1);
		acc(0, 8'h08, 0);
		chk(q, 32'hFF);
	endtask
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		pwr <= 1'b0;
		@(posedge hclk);
		t_reset();
		t_rate();
		t_ext();
		t_warm();
		stop_test();
	end
endmodule
